// ### hdl/pcgu_pkg.sv
// Constants and carrier types of the peripheral clock gate unit.
// Assumes a single system clock and an APB style register port.
package pcgu_pkg;

  // Register map, byte addresses
  localparam logic [31:0] PCGU_ADDR_UNLOCK = 32'h8000_0600;
  localparam logic [31:0] PCGU_ADDR_ENABLE = 32'h8000_0604;
  localparam logic [31:0] PCGU_ADDR_HOLD   = 32'h8000_0608;

  // Register width, channel count and reset values
  localparam int          PCGU_REG_W       = 8;
  localparam int          PCGU_CHAN_N      = 7;
  localparam logic [7:0]  PCGU_UNLOCK_RST  = 8'h00;
  localparam logic [7:0]  PCGU_ENABLE_RST  = 8'h7f;
  localparam logic [7:0]  PCGU_HOLD_RST    = 8'h00;
  localparam logic [31:0] PCGU_RDATA_RST   = 32'h0000_0000;

  // Channel bit positions
  localparam int          PCGU_BIT_CAN     = 4;
  localparam int          PCGU_BIT_MAC     = 5;
  localparam int          PCGU_BIT_PCI     = 6;
  localparam int          PCGU_BIT_SPARE   = 7;

  // Register port request
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pcgu_apb_req_t;

  // Register port answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pcgu_apb_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [7:0]  unlock;
    logic [7:0]  enable;
    logic [7:0]  hold;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } pcgu_state_t;

  // Whole state of one channel
  typedef struct packed {
    logic clk_en;
    logic core_rst;
  } pcgu_chan_t;

endpackage

// ### hdl/pcgu_chan.sv
// One gated peripheral channel: registered clock enable and core reset.
// Assumes enable and hold bits come from registers in the same domain.
`timescale 1ns/100ps
`default_nettype none
module pcgu_chan
  import pcgu_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic hold_i,
  output var  logic clk_en_o,
  output var  logic core_rst_o
);

  pcgu_chan_t s_q;
  pcgu_chan_t s_d;

  // Lines follow the register bits, no idle guard
  always_comb begin
    s_d          = s_q;
    s_d.clk_en   = enable_i;
    s_d.core_rst = hold_i;
  end

  // Reset leaves clock running and reset released
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{clk_en: PCGU_ENABLE_RST[0], core_rst: PCGU_HOLD_RST[0]};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_en_o   = s_q.clk_en;
  assign core_rst_o = s_q.core_rst;

endmodule
`default_nettype wire

// ### hdl/pcgu_top.sv
// Peripheral clock gate unit: unlock, clock enable and core reset hold
// registers on an APB style port, driving per-peripheral clock enables
// and core resets.
// Assumes one system clock; the clock enables feed glitch-free gate
// cells outside this block.
//
// Contract
// - Seven channels, each with its own clock enable and reset.
// - Clock runs while enable bit is one, stops while zero.
// - Core reset asserted while its hold bit is one.
// - Enable and hold bits writable only while matching unlock bit set.
// - Lines follow register bits directly, no peripheral idle check.
// - Bits 0-3 serial links, 4 both CAN, 5 MAC, 6 PCI bridge.
// - Registers at 0x80000600 up; enable resets to 0x7f, others zero.
`timescale 1ns/100ps
`default_nettype none
module pcgu_top
  import pcgu_pkg::*;
#(
  parameter int CHAN_N = PCGU_CHAN_N
)(
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire pcgu_apb_req_t       apb_req_i,
  output var  pcgu_apb_rsp_t       apb_rsp_o,
  output var  logic [CHAN_N-1:0]   clk_en_o,
  output var  logic [CHAN_N-1:0]   core_rst_o
);

  pcgu_state_t s_q;
  pcgu_state_t s_d;
  logic        rst_b;
  logic        setup_ph;
  logic        wr_acc;
  logic        hit_unlock;
  logic        hit_enable;
  logic        hit_hold;
  logic [7:0]  wbyte;

  //////////////////////////////////////////////////////////////////////
  // Reset image of the whole state; the sync pair starts cleared
  localparam pcgu_state_t STATE_RST = '{
    rst_sync: '0,
    unlock:   PCGU_UNLOCK_RST,
    enable:   PCGU_ENABLE_RST,
    hold:     PCGU_HOLD_RST,
    ready:    1'b0,
    slverr:   1'b0,
    rdata:    PCGU_RDATA_RST
  };

  // Released copy of reset is the second sync flop
  assign rst_b = s_q.rst_sync[1];

  //////////////////////////////////////////////////////////////////////
  // Address decode, full 32-bit compare
  assign hit_unlock = (apb_req_i.paddr == PCGU_ADDR_UNLOCK);
  assign hit_enable = (apb_req_i.paddr == PCGU_ADDR_ENABLE);
  assign hit_hold   = (apb_req_i.paddr == PCGU_ADDR_HOLD);
  assign setup_ph   = apb_req_i.psel && !apb_req_i.penable;
  assign wr_acc     = apb_req_i.psel && apb_req_i.penable &&
                      apb_req_i.pwrite && s_q.ready;
  assign wbyte      = apb_req_i.pwdata[PCGU_REG_W-1:0];

  // Register updates and answer for the next access phase
  always_comb begin
    s_d          = s_q;
    s_d.ready    = setup_ph;
    s_d.slverr   = setup_ph && !(hit_unlock || hit_enable || hit_hold);
    s_d.rdata    = PCGU_RDATA_RST;
    // Read data captured in setup, upper bits read as zero
    if (setup_ph && !apb_req_i.pwrite) begin
      if (hit_unlock) begin
        s_d.rdata[PCGU_REG_W-1:0] = s_q.unlock;
      end else if (hit_enable) begin
        s_d.rdata[PCGU_REG_W-1:0] = s_q.enable;
      end else if (hit_hold) begin
        s_d.rdata[PCGU_REG_W-1:0] = s_q.hold;
      end
    end
    // Locked bits keep their value, unlocked ones take the write
    if (wr_acc) begin
      if (hit_unlock) begin
        s_d.unlock = wbyte;
      end else if (hit_enable) begin
        s_d.enable = (s_q.enable & ~s_q.unlock) |
                     (wbyte & s_q.unlock);
      end else if (hit_hold) begin
        s_d.hold = (s_q.hold & ~s_q.unlock) |
                   (wbyte & s_q.unlock);
      end
    end
    // Held at reset values until the released copy rises
    if (!rst_b) begin
      s_d = STATE_RST;
    end
    // Sync pair shifts in ones once the raw reset is gone
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
  end

  // Whole state in one flop bank; raw reset loads STATE_RST at once, so
  // one process drives every field
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Answer straight from the flops
  assign apb_rsp_o = '{pready:  s_q.ready,
                       pslverr: s_q.slverr,
                       prdata:  s_q.rdata};

  //////////////////////////////////////////////////////////////////////
  // One channel per connected bit; spare bit 7 has no channel
  for (genvar gi = 0; gi < CHAN_N; gi++) begin : g_chan
    pcgu_chan u_chan (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b),
      .enable_i   (s_q.enable[gi]),
      .hold_i     (s_q.hold[gi]),
      .clk_en_o   (clk_en_o[gi]),
      .core_rst_o (core_rst_o[gi])
    );
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  property p_clk_follow;
    ##1 clk_en_o == $past(s_q.enable[CHAN_N-1:0]);
  endproperty
  a_clk_follow: assert property (p_clk_follow)
    else $error("clock enable does not follow enable register");

  property p_hold_reset;
    s_q.hold[0] [*2] |-> core_rst_o[0];
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("core reset not asserted while hold bit set");

  property p_locked_write;
    (wr_acc && hit_enable && !s_q.unlock[0]) |=> $stable(s_q.enable[0]);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("locked enable bit changed by write");

  property p_unlocked_write;
    (wr_acc && hit_hold && s_q.unlock[1]) |=>
      s_q.hold[1] == $past(apb_req_i.pwdata[1]) ##1
      core_rst_o[1] == $past(apb_req_i.pwdata[1], 2);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write)
    else $error("unlocked hold write not reflected on reset line");

  property p_no_idle_check;
    (wr_acc && hit_enable && s_q.unlock[PCGU_BIT_MAC] &&
     !apb_req_i.pwdata[PCGU_BIT_MAC]) |-> ##2 !clk_en_o[PCGU_BIT_MAC];
  endproperty
  a_no_idle_check: assert property (p_no_idle_check)
    else $error("clock not stopped two cycles after disable write");

  property p_can_map;
    ##1 core_rst_o[PCGU_BIT_CAN] == $past(s_q.hold[PCGU_BIT_CAN]);
  endproperty
  a_can_map: assert property (p_can_map)
    else $error("shared CAN reset not mapped to bit four");

  property p_reset_vals;
    $rose(rst_b) |-> s_q.enable == PCGU_ENABLE_RST &&
      s_q.unlock == PCGU_UNLOCK_RST && s_q.hold == PCGU_HOLD_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset values wrong");

  property p_spare_read;
    (setup_ph && !apb_req_i.pwrite && hit_enable) |=>
      apb_rsp_o.pready && apb_rsp_o.prdata[PCGU_BIT_SPARE] ==
      $past(s_q.enable[PCGU_BIT_SPARE]) && apb_rsp_o.prdata[31:8] == 24'h0;
  endproperty
  a_spare_read: assert property (p_spare_read)
    else $error("spare bit not read back");

  property p_locked_hold;
    (wr_acc && hit_hold && !s_q.unlock[2]) |=> $stable(s_q.hold[2]);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("locked hold bit changed by write");

  // Unlock register itself is never locked
  property p_unlock_free;
    (wr_acc && hit_unlock) |=>
      s_q.unlock == $past(apb_req_i.pwdata[PCGU_REG_W-1:0]);
  endproperty
  a_unlock_free: assert property (p_unlock_free)
    else $error("unlock register did not take the write");

  property p_unlocked_enable;
    (wr_acc && hit_enable && s_q.unlock[PCGU_BIT_PCI]) |=>
      s_q.enable[PCGU_BIT_PCI] == $past(apb_req_i.pwdata[PCGU_BIT_PCI]);
  endproperty
  a_unlocked_enable: assert property (p_unlocked_enable)
    else $error("unlocked enable bit did not take the write");

  property p_hold_release;
    !s_q.hold[3] [*2] |-> !core_rst_o[3];
  endproperty
  a_hold_release: assert property (p_hold_release)
    else $error("core reset still asserted after hold cleared");

  // Holes in the map answer with an error and no data
  property p_unmapped_err;
    (setup_ph && !(hit_unlock || hit_enable || hit_hold)) |=>
      apb_rsp_o.pready && apb_rsp_o.pslverr &&
      apb_rsp_o.prdata == PCGU_RDATA_RST;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not answered with error");

  property p_write_no_data;
    (setup_ph && apb_req_i.pwrite) |=> apb_rsp_o.prdata == PCGU_RDATA_RST;
  endproperty
  a_write_no_data: assert property (p_write_no_data)
    else $error("read data not zero during a write");

endmodule
`default_nettype wire

// ### test/tb_pcgu_top.sv
// Self-checking bench of the peripheral clock gate unit.
// Assumes pcgu_pkg and pcgu_top are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_pcgu_top
  import pcgu_pkg::*;
();
  logic          clk_i;
  logic          rst_b_i;
  pcgu_apb_req_t req;
  pcgu_apb_rsp_t rsp;
  logic [6:0]    clk_en;
  logic [6:0]    core_rst;
  int            err_count;
  int            check_count;
  logic [31:0]   rd;

  pcgu_top #(.CHAN_N(PCGU_CHAN_N)) dut (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .apb_req_i  (req),
    .apb_rsp_o  (rsp),
    .clk_en_o   (clk_en),
    .core_rst_o (core_rst)
  );

  // 20 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One bus transfer; request held until pready seen, bounded wait
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
    int   n;
    logic eerr;
    n = 0;
    eerr = !(a inside {PCGU_ADDR_UNLOCK, PCGU_ADDR_ENABLE, PCGU_ADDR_HOLD});
    @(posedge clk_i);
    req.psel   <= 1'b1;
    req.pwrite <= wr;
    req.paddr  <= a;
    req.pwdata <= d;
    @(posedge clk_i);
    req.penable <= 1'b1;
    @(negedge clk_i);
    while (rsp.pready !== 1'b1) begin
      n++;
      if (n > 8) begin
        err_count++;
        summarize();
      end
      @(negedge clk_i);
    end
    rd = rsp.prdata;
    chk({31'h0, rsp.pslverr}, {31'h0, eerr});
    @(posedge clk_i);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask

  // Lines follow a register two edges after the write commits
  task automatic out_chk(input logic [6:0] en, input logic [6:0] hr);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({25'h0, clk_en}, {25'h0, en});
    chk({25'h0, core_rst}, {25'h0, hr});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    out_chk(7'h7f, 7'h00);
    rd_chk(PCGU_ADDR_UNLOCK, 8'h00);
    rd_chk(PCGU_ADDR_ENABLE, 8'h7f);
    rd_chk(PCGU_ADDR_HOLD, 8'h00);
  endtask

  // Locked writes leave both registers and the lines alone
  task automatic t_locked();
    wr(PCGU_ADDR_ENABLE, 8'h00);
    wr(PCGU_ADDR_HOLD, 8'hff);
    rd_chk(PCGU_ADDR_ENABLE, 8'h7f);
    rd_chk(PCGU_ADDR_HOLD, 8'h00);
    out_chk(7'h7f, 7'h00);
  endtask

  // Off then on per channel; all-ones data shows only one bit unlocked
  task automatic t_chan();
    logic [7:0] m;
    for (int i = 0; i < PCGU_CHAN_N; i++) begin
      m = 8'h01 << i;
      wr(PCGU_ADDR_UNLOCK, m);
      rd_chk(PCGU_ADDR_UNLOCK, m);
      wr(PCGU_ADDR_HOLD, 8'hff);
      out_chk(7'h7f, m[6:0]);
      wr(PCGU_ADDR_ENABLE, 8'h00);
      rd_chk(PCGU_ADDR_ENABLE, 8'h7f & ~m);
      out_chk(7'h7f & ~m[6:0], m[6:0]);
      wr(PCGU_ADDR_UNLOCK, 8'h00);
      wr(PCGU_ADDR_ENABLE, 8'hff);
      rd_chk(PCGU_ADDR_ENABLE, 8'h7f & ~m);
      wr(PCGU_ADDR_UNLOCK, m);
      wr(PCGU_ADDR_ENABLE, 8'h7f);
      out_chk(7'h7f, m[6:0]);
      wr(PCGU_ADDR_HOLD, 8'h00);
      out_chk(7'h7f, 7'h00);
      wr(PCGU_ADDR_UNLOCK, 8'h00);
    end
  endtask

  // Spare bit stored but drives nothing
  task automatic t_spare();
    wr(PCGU_ADDR_UNLOCK, 8'h80);
    wr(PCGU_ADDR_ENABLE, 8'h7f);
    wr(PCGU_ADDR_HOLD, 8'h80);
    rd_chk(PCGU_ADDR_HOLD, 8'h80);
    out_chk(7'h7f, 7'h00);
    wr(PCGU_ADDR_ENABLE, 8'hff);
    rd_chk(PCGU_ADDR_ENABLE, 8'hff);
    wr(PCGU_ADDR_HOLD, 8'h00);
    wr(PCGU_ADDR_UNLOCK, 8'h00);
  endtask

  // Hole after the map: error answer, read zero, nothing disturbed
  task automatic t_unmapped();
    wr(PCGU_ADDR_HOLD + 32'h4, 8'hff);
    rd_chk(PCGU_ADDR_HOLD + 32'h4, 8'h00);
    rd_chk(PCGU_ADDR_UNLOCK, 8'h00);
    out_chk(7'h7f, 7'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    req = '0;
    err_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_locked();
    t_chan();
    t_spare();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
